// ### hb_fabric_model.sv
// host fabric model: takes released transactions, reports ordered then visible points
// assumes one clock, a fixed report delay per tracked slot, and a stall input from the bench
`timescale 1ns/100ps
module hb_fabric_model #(
  parameter int SLOTS = 8,
  parameter int GO_D = 10,
  parameter int GV_D = 30
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // release side
  input wire logic out_valid,
  input wire logic out_tracked,
  input wire logic [$clog2(SLOTS)-1:0] out_slot,
  input wire logic stall,
  output logic out_ready,
  // ordering point reports
  output logic go_pulse,
  output logic [$clog2(SLOTS)-1:0] go_slot,
  output logic gv_pulse,
  output logic [$clog2(SLOTS)-1:0] gv_slot
);
  localparam int SW = $clog2(SLOTS);
  logic [SLOTS-1:0] busy_reg;
  int age_reg [SLOTS];
  // stall holds the release stage full
  assign out_ready = !stall;
  // visible always trails ordered by a margin, as caches settle late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= '0;
      go_pulse <= 1'b0;
      gv_pulse <= 1'b0;
      go_slot <= '0;
      gv_slot <= '0;
      for (int i = 0; i < SLOTS; i++) age_reg[i] <= 0;
    end else begin
      go_pulse <= 1'b0;
      gv_pulse <= 1'b0;
      go_slot <= ~go_slot; // idle slot lines keep moving
      gv_slot <= ~gv_slot;
      for (int i = 0; i < SLOTS; i++) begin
        if (busy_reg[i]) begin
          age_reg[i] <= age_reg[i] + 1;
          if (age_reg[i] == GO_D) begin
            go_pulse <= 1'b1;
            go_slot <= SW'(i);
          end
          if (age_reg[i] == GV_D) begin
            gv_pulse <= 1'b1;
            gv_slot <= SW'(i);
            busy_reg[i] <= 1'b0;
          end
        end
      end
      if (out_valid && out_ready && out_tracked) begin
        busy_reg[out_slot] <= 1'b1;
        age_reg[out_slot] <= 0;
      end
    end
  end
endmodule

// ### hb_order_pkg.sv
// constants and types shared by the host bridge ordering engine
// assumes one 50 MHz clock domain and an AHB-Lite register slave
package hb_order_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CNT_OFS = 8'h08;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STRICT_BIT = 1;
  localparam int CTRL_EP_BIT = 2;
  localparam int CTRL_TAG_LSB = 4;
  // status field positions
  localparam int STAT_HOLD_BIT = 8;
  localparam int STAT_OUT_BIT = 9;
  localparam int STAT_STALL_BIT = 10;
  // reset values
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [4:0] HOST_TAG = 5'h00;
  localparam logic [3:0] SEQ_NONE = 4'h0;
  // widths
  localparam int TAG_W = 5;
  localparam int SEQ_W = 4;
  // ordering point that a second transaction waits for
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_GO = 2'h1;
  localparam logic [1:0] WAIT_GV = 2'h2;
  // bus transfer size of a whole word
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // target space of a transaction
  typedef enum logic [2:0] {
    CLS_CW = 3'h0,
    CLS_CR = 3'h1,
    CLS_NC = 3'h2,
    CLS_INTR = 3'h3,
    CLS_FLUSH = 3'h4,
    CLS_FENCE = 3'h5,
    CLS_RESP = 3'h6
  } class_t;
  // one classified transaction
  typedef struct packed {
    logic valid;
    class_t cls;
    logic posted;
    logic upstream;
    logic pass_posted;
    logic local_acc;
    logic external;
    logic [TAG_W-1:0] tag;
    logic [SEQ_W-1:0] seq;
  } txn_t;
endpackage

// ### host_bridge_ordering_engine.sv
// ordering engine of a host bridge: holds each transaction until the
// earlier ones it depends on have reached ordered or visible points
// assumes link and fabric logic on hclk, AHB-Lite register access
`timescale 1ns/100ps
module host_bridge_ordering_engine
  import hb_order_pkg::*;
#(
  parameter int SLOTS = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // classified transaction from the link side
  input wire logic in_valid,
  input wire logic [2:0] in_class,
  input wire logic in_posted,
  input wire logic in_upstream,
  input wire logic in_pass_posted,
  input wire logic in_local,
  input wire logic in_external,
  input wire logic [TAG_W-1:0] in_link_source_tag,
  input wire logic [SEQ_W-1:0] in_sequence_tag,
  output logic in_ready,
  // released transaction toward the host fabric
  output logic out_valid,
  output logic [2:0] out_class,
  output logic out_posted,
  output logic out_upstream,
  output logic out_external,
  output logic [TAG_W-1:0] out_link_source_tag,
  output logic [SEQ_W-1:0] out_sequence_tag,
  output logic out_tracked,
  output logic [$clog2(SLOTS)-1:0] out_slot,
  input wire logic out_ready,
  // ordering point reports from the fabric, and response side-effect completion
  input wire logic go_pulse,
  input wire logic [$clog2(SLOTS)-1:0] go_slot,
  input wire logic gv_pulse,
  input wire logic [$clog2(SLOTS)-1:0] gv_slot,
  input wire logic resp_side_done
);
  localparam int SW = $clog2(SLOTS);

  typedef struct packed {
    txn_t t;
    logic go;
    logic gv;
  } slot_t;

  typedef struct packed {
    slot_t [SLOTS-1:0] slots;
    txn_t hold;
    txn_t outq;
    logic out_trk;
    logic [SW-1:0] out_idx;
    logic in_rdy;
    logic [2:0] ctrl;
    logic [TAG_W-1:0] ep_tag;
    logic [15:0] issued;
    logic stall;
    logic a_act;
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] rdata;
    logic rdy;
  } state_t;

  state_t s_reg, s_next;
  logic blocked;
  logic issue;
  logic has_free;
  logic [SW-1:0] free_idx;
  logic [TAG_W-1:0] host_tag;

  // wait figure for a pair by target space and whether the first is posted
  function automatic logic [1:0] table_wait(class_t f, logic fp, class_t s);
    logic [1:0] w;
    w = WAIT_NONE;
    if (f == CLS_FLUSH || f == CLS_RESP) begin
      w = WAIT_NONE;
    end else if (f == CLS_FENCE) begin
      w = WAIT_GV;
    end else if (s == CLS_FENCE) begin
      case (f)
        CLS_CW: w = fp ? WAIT_GV : WAIT_NONE;
        CLS_NC: w = fp ? WAIT_GO : WAIT_NONE;
        CLS_INTR: w = WAIT_GV;
        default: w = WAIT_NONE;
      endcase
    end else begin
      case (f)
        CLS_CW: w = (s == CLS_CR) ? WAIT_GO : WAIT_GV;
        CLS_CR: w = (s == CLS_CW || s == CLS_CR || s == CLS_NC) ? WAIT_GO : WAIT_NONE;
        CLS_NC: w = WAIT_GO;
        CLS_INTR: w = (s == CLS_RESP) ? WAIT_GV : WAIT_NONE;
        default: w = WAIT_NONE;
      endcase
    end
    return w;
  endfunction

  // whether two transactions share an i/o stream
  function automatic logic same_stream(txn_t a, txn_t b, logic [TAG_W-1:0] ht);
    logic m;
    if (a.cls == CLS_FENCE || b.cls == CLS_FENCE) begin
      m = 1'b1; // a fence orders against every source, as first or second
    end else if (!a.upstream && !b.upstream) begin
      m = 1'b1;
    end else if (a.upstream && b.upstream) begin
      m = (a.tag == b.tag);
    end else begin
      m = (a.tag == b.tag) && (a.tag == ht);
    end
    return m;
  endfunction

  // virtual channel of a transaction
  function automatic logic [1:0] chan(txn_t t);
    return t.posted ? 2'h0 : ((t.cls == CLS_RESP) ? 2'h2 : 2'h1);
  endfunction

  // point that earlier f must reach before later s may take effect
  function automatic logic [1:0] need(txn_t f, txn_t s, logic strict, logic [TAG_W-1:0] ht);
    logic [1:0] w;
    w = WAIT_NONE;
    if (f.local_acc == s.local_acc && same_stream(f, s, ht)) begin
      w = table_wait(f.cls, f.posted, s.cls);
      if (f.upstream != s.upstream && s.cls == CLS_RESP && f.posted && !s.pass_posted) begin
        // opposite directions: response pushes posted writes unless flagged
        // only ever raises the wait, so a cacheable write still needs visible
        w = (w == WAIT_NONE) ? WAIT_GO : w;
      end
      if (w == WAIT_NONE && f.seq != SEQ_NONE && f.seq == s.seq && chan(f) == chan(s)) begin
        w = WAIT_GO;
      end
      if (w == WAIT_GV && f.external) begin
        w = WAIT_GO;
      end
      if (strict && w != WAIT_NONE) begin
        w = WAIT_GV;
      end
    end
    return w;
  endfunction

  // register read mux, unmapped offsets read zero
  function automatic logic [31:0] rd_mux(state_t s, logic [7:0] ofs);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (ofs)
      CTRL_OFS: begin
        d[CTRL_EN_BIT] = s.ctrl[CTRL_EN_BIT];
        d[CTRL_STRICT_BIT] = s.ctrl[CTRL_STRICT_BIT];
        d[CTRL_EP_BIT] = s.ctrl[CTRL_EP_BIT];
        d[CTRL_TAG_LSB +: TAG_W] = s.ep_tag;
      end
      STAT_OFS: begin
        for (int i = 0; i < SLOTS; i++) begin
          d[i] = s.slots[i].t.valid;
        end
        d[STAT_HOLD_BIT] = s.hold.valid;
        d[STAT_OUT_BIT] = s.outq.valid;
        d[STAT_STALL_BIT] = s.stall;
      end
      CNT_OFS: d[15:0] = s.issued;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // host tag: zero unless the host acts as an endpoint
  assign host_tag = s_reg.ctrl[CTRL_EP_BIT] ? s_reg.ep_tag : HOST_TAG;

  // next state: fabric reports, release, intake and registers
  always_comb begin
    s_next = s_reg;
    blocked = 1'b0;
    has_free = 1'b0;
    free_idx = '0;
    // ordering point reports; visible implies ordered
    for (int i = 0; i < SLOTS; i++) begin
      if (s_reg.slots[i].t.valid) begin
        if (go_pulse && go_slot == SW'(i)) begin
          s_next.slots[i].go = 1'b1;
          if (s_reg.slots[i].t.external) begin
            s_next.slots[i].t.valid = 1'b0;
          end
        end
        if (gv_pulse && gv_slot == SW'(i)) begin
          s_next.slots[i].go = 1'b1;
          s_next.slots[i].gv = 1'b1;
          s_next.slots[i].t.valid = 1'b0; // nothing waits past visible
        end
      end
    end
    // every tracked earlier transaction is a possible first of a pair
    for (int i = 0; i < SLOTS; i++) begin
      if (s_reg.slots[i].t.valid) begin
        case (need(s_reg.slots[i].t, s_reg.hold, s_reg.ctrl[CTRL_STRICT_BIT], host_tag))
          WAIT_GO: blocked = blocked | !(s_reg.slots[i].go || s_reg.slots[i].gv);
          WAIT_GV: blocked = blocked | !s_reg.slots[i].gv;
          default: blocked = blocked;
        endcase
      end else if (!has_free) begin
        has_free = 1'b1;
        free_idx = SW'(i);
      end
    end
    // release: flush and response are never firsts, so they take no slot
    issue = s_reg.hold.valid && s_reg.ctrl[CTRL_EN_BIT] && !blocked
          && (!s_reg.outq.valid || out_ready)
          && (s_reg.hold.cls == CLS_FLUSH || s_reg.hold.cls == CLS_RESP || has_free)
          && (s_reg.hold.cls != CLS_RESP || resp_side_done);
    if (s_reg.outq.valid && out_ready) begin
      s_next.outq.valid = 1'b0;
    end
    if (issue) begin
      s_next.outq = s_reg.hold;
      s_next.hold.valid = 1'b0;
      s_next.out_trk = 1'b0;
      s_next.out_idx = free_idx;
      s_next.issued = s_reg.issued + 16'h0001;
      if (s_reg.hold.cls != CLS_FLUSH && s_reg.hold.cls != CLS_RESP) begin
        s_next.out_trk = 1'b1;
        s_next.slots[free_idx].t = s_reg.hold;
        s_next.slots[free_idx].go = 1'b0;
        s_next.slots[free_idx].gv = 1'b0;
      end
    end
    s_next.stall = s_reg.hold.valid && !issue;
    // intake into the single holding stage
    if (s_reg.in_rdy && in_valid) begin
      s_next.hold.valid = 1'b1;
      s_next.hold.cls = class_t'(in_class);
      s_next.hold.posted = in_posted;
      s_next.hold.upstream = in_upstream;
      s_next.hold.pass_posted = in_pass_posted;
      s_next.hold.local_acc = in_local;
      s_next.hold.external = in_external;
      s_next.hold.tag = in_link_source_tag;
      s_next.hold.seq = in_sequence_tag;
    end
    s_next.in_rdy = !s_next.hold.valid;
    // ahb-lite: zero wait states, always okay
    s_next.rdy = 1'b1;
    if (s_reg.a_act && s_reg.a_wr && s_reg.a_ofs == CTRL_OFS) begin
      s_next.ctrl[CTRL_EN_BIT] = hwdata[CTRL_EN_BIT];
      s_next.ctrl[CTRL_STRICT_BIT] = hwdata[CTRL_STRICT_BIT];
      s_next.ctrl[CTRL_EP_BIT] = hwdata[CTRL_EP_BIT];
      s_next.ep_tag = hwdata[CTRL_TAG_LSB +: TAG_W];
    end
    s_next.a_act = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_next.a_act = (hsize == HSIZE_WORD); // writes of other sizes are ignored
      s_next.a_wr = hwrite;
      s_next.a_ofs = {haddr[7:2], 2'h0};
      if (!hwrite) begin
        s_next.rdata = rd_mux(s_reg, {haddr[7:2], 2'h0});
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register, hresp tied low
  assign hrdata = s_reg.rdata;
  assign hreadyout = s_reg.rdy;
  assign hresp = 1'b0;
  assign in_ready = s_reg.in_rdy;
  assign out_valid = s_reg.outq.valid;
  assign out_class = s_reg.outq.cls;
  assign out_posted = s_reg.outq.posted;
  assign out_upstream = s_reg.outq.upstream;
  assign out_external = s_reg.outq.external;
  assign out_link_source_tag = s_reg.outq.tag;
  assign out_sequence_tag = s_reg.outq.seq;
  assign out_tracked = s_reg.out_trk;
  assign out_slot = s_reg.out_idx;

  // helpers for the checks below, written apart from the wait function
  logic fence_pend;
  logic cw_pend;
  logic seq_pend;
  always_comb begin
    fence_pend = 1'b0;
    cw_pend = 1'b0;
    seq_pend = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (s_reg.slots[i].t.valid && s_reg.slots[i].t.local_acc == s_reg.hold.local_acc) begin
        // a fence holds back later traffic of every source and direction
        fence_pend = fence_pend | (s_reg.slots[i].t.cls == CLS_FENCE && !s_reg.slots[i].gv
                     && !s_reg.slots[i].t.external);
        if (!s_reg.slots[i].t.upstream && !s_reg.hold.upstream) begin
          cw_pend = cw_pend | (s_reg.slots[i].t.cls == CLS_CW && !s_reg.slots[i].gv
                    && !s_reg.slots[i].t.external);
          // responses sit in their own channel, so a shared tag does not bind them
          seq_pend = seq_pend | (s_reg.slots[i].t.seq == s_reg.hold.seq
                     && s_reg.hold.seq != SEQ_NONE && !s_reg.slots[i].go
                     && s_reg.slots[i].t.posted == s_reg.hold.posted
                     && s_reg.hold.cls != CLS_RESP);
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_out_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_class))
    else $error("released transaction dropped before fabric took it");
  a_hold_stall: assert property (s_reg.hold.valid && blocked |=> s_reg.hold.valid)
    else $error("blocked transaction left the holding stage");
  a_take_hold: assert property (in_valid && in_ready |=> s_reg.hold.valid && !in_ready)
    else $error("accepted transaction not held");
  a_resp_side: assert property (issue && s_reg.hold.cls == CLS_RESP |-> resp_side_done ##1 out_valid)
    else $error("response released before side effects done");
  a_after_fence: assert property (fence_pend && s_reg.hold.valid |-> !issue)
    else $error("transaction passed an unfinished fence");
  a_cw_visible: assert property (cw_pend && s_reg.hold.cls == CLS_NC |-> !issue)
    else $error("non-cacheable access passed invisible cacheable write");
  a_seq_order: assert property (seq_pend && s_reg.hold.valid |-> !issue)
    else $error("sequence member passed earlier unordered member");
  a_gv_frees: assert property (gv_pulse && s_reg.slots[gv_slot].t.valid
      |=> !s_reg.slots[$past(gv_slot)].t.valid)
    else $error("visible slot not retired");
  a_ext_frees: assert property (go_pulse && s_reg.slots[go_slot].t.valid
      && s_reg.slots[go_slot].t.external |=> !s_reg.slots[$past(go_slot)].t.valid)
    else $error("peer slot not retired when ordered");
  a_flush_free: assert property (issue && s_reg.hold.cls == CLS_FLUSH |=> !out_tracked)
    else $error("flush given a tracking slot");
endmodule

// ### host_bridge_ordering_engine_tb.sv
// testbench of the ordering engine: pairs of transactions timed against fabric reports
// assumes the fabric model reports ordered 10 and visible 30 cycles after acceptance
`timescale 1ns/100ps
module host_bridge_ordering_engine_tb;
  import hb_order_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hrdata;
  logic hready, hreadyout, in_ready, out_valid, out_posted, out_upstream, out_external;
  logic in_valid = 1'b0, in_posted = 1'b0, in_upstream = 1'b0, resp_done = 1'b1, stall = 1'b0;
  logic in_ext = 1'b0, in_loc = 1'b1, in_pp = 1'b0;
  logic [2:0] in_class = 3'h0, out_class, rel_cls;
  logic [4:0] in_tag = 5'h00, out_link_source_tag;
  logic [3:0] in_seq = 4'h0, out_sequence_tag;
  logic out_tracked, out_ready, go_pulse, gv_pulse;
  logic [2:0] out_slot, go_slot, gv_slot;
  int fails = 0, n_tests = 0, rel_n = 0;
  time rel_t = 0;
  // {first class, posted, second class, posted, wait}
  logic [9:0] tbl [23] = '{10'h046, 10'h049, 10'h089, 10'h085, 10'h155, 10'h056, 10'h091,
    10'h105, 10'h062, 10'h05E, 10'h072, 10'h0A0, 10'h0B0, 10'h11D, 10'h204, 10'h310,
    10'h1EE, 10'h1F2, 10'h1C4, 10'h06E, 10'h16D, 10'h0AC, 10'h2CA};
  assign hready = hreadyout;
  // clock
  initial begin
    forever #10 hclk = ~hclk;
  end
  host_bridge_ordering_engine dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .in_valid(in_valid),
    .in_class(in_class), .in_posted(in_posted), .in_upstream(in_upstream),
    .in_pass_posted(in_pp), .in_local(in_loc), .in_external(in_ext),
    .in_link_source_tag(in_tag), .in_sequence_tag(in_seq), .in_ready(in_ready),
    .out_valid(out_valid), .out_class(out_class), .out_posted(out_posted),
    .out_upstream(out_upstream), .out_external(out_external),
    .out_link_source_tag(out_link_source_tag), .out_sequence_tag(out_sequence_tag),
    .out_tracked(out_tracked), .out_slot(out_slot), .out_ready(out_ready),
    .go_pulse(go_pulse), .go_slot(go_slot), .gv_pulse(gv_pulse), .gv_slot(gv_slot),
    .resp_side_done(resp_done));
  hb_fabric_model fab_u (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
    .out_tracked(out_tracked), .out_slot(out_slot), .stall(stall), .out_ready(out_ready),
    .go_pulse(go_pulse), .go_slot(go_slot), .gv_pulse(gv_pulse), .gv_slot(gv_slot));
  // release monitor
  always @(posedge hclk) begin
    if (out_valid === 1'b1 && out_ready) begin
      rel_n++;
      rel_t = $time;
      rel_cls = out_class;
    end
  end
  task automatic stop_test();
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // offer one transaction and hold it until taken; class and tag scrambled afterwards
  task automatic offer(input logic [2:0] c, input logic p, input logic u,
    input logic [4:0] t, input logic [3:0] s);
    @(posedge hclk);
    in_valid <= 1'b1;
    in_class <= c;
    in_posted <= p;
    in_upstream <= u;
    in_tag <= t;
    in_seq <= s;
    do @(posedge hclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_class <= ~c;
    in_tag <= ~t;
  endtask
  task automatic wait_rel(input int n, input int lim);
    for (int i = 0; i < lim && rel_n < n; i++) @(posedge hclk);
  endtask
  // release time of the second, counted from the first's take, gives the wait kind
  task automatic pair(input logic [9:0] c, input logic [4:0] tf, input logic [4:0] ts,
    input logic uf, input logic us, input logic [3:0] sq);
    time t0;
    int d, n0;
    logic [1:0] cat;
    n0 = rel_n;
    offer(c[9:7], c[6], uf, tf, sq);
    t0 = $time;
    offer(c[5:3], c[2], us, ts, sq);
    wait_rel(n0 + 2, 80);
    d = int'((rel_t - t0) / 20);
    cat = d < 10 ? WAIT_NONE : d < 30 ? WAIT_GO : d < 60 ? WAIT_GV : 2'h3;
    if (rel_n < n0 + 2) cat = 2'h3;
    check("wait", cat, c[1:0]);
    check("class", rel_cls, c[5:3]);
    repeat (50) @(posedge hclk);
  endtask
  // release withheld while disabled or while response side effects pend
  task automatic t_hold(input logic [2:0] c);
    int n0;
    logic [31:0] r;
    n0 = rel_n;
    if (c == CLS_RESP) resp_done <= 1'b0;
    else bus(1'b1, CTRL_OFS, 32'h00000000, r);
    offer(c, 1'b0, 1'b1, 5'h01, 4'h0);
    repeat (15) @(posedge hclk);
    check("held", rel_n - n0, 0);
    resp_done <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'h00000001, r);
    wait_rel(n0 + 1, 20);
    check("freed", rel_n - n0, 1);
    repeat (50) @(posedge hclk);
  endtask
  task automatic t_stall();
    int n0;
    n0 = rel_n;
    stall <= 1'b1;
    offer(CLS_CR, 1'b0, 1'b1, 5'h05, 4'h3);
    repeat (6) @(posedge hclk);
    check("stall_valid", out_valid, 1);
    check("stall_tag", out_link_source_tag, 5'h05);
    check("stall_dir", out_upstream, 1);
    check("stall_seq", out_sequence_tag, 4'h3);
    stall <= 1'b0;
    wait_rel(n0 + 1, 10);
    check("stall_done", rel_n - n0, 1);
    repeat (50) @(posedge hclk);
  endtask
  // peer targets retire at ordered; flagged responses; accepted vs forwarded traffic
  task automatic t_side();
    int n0;
    time t0;
    in_ext <= 1'b1;
    pair(10'h045, 5'h01, 5'h01, 1'b1, 1'b1, 4'h0);
    in_ext <= 1'b0;
    in_pp <= 1'b1;
    pair(10'h072, 5'h00, 5'h00, 1'b0, 1'b1, 4'h0);
    in_pp <= 1'b0;
    n0 = rel_n;
    offer(CLS_CW, 1'b1, 1'b0, 5'h01, 4'h0);
    t0 = $time;
    in_loc <= 1'b0;
    offer(CLS_CW, 1'b1, 1'b0, 5'h01, 4'h0);
    wait_rel(n0 + 2, 80);
    check("local", (rel_n == n0 + 2) && (rel_t - t0 < 200), 1);
    in_loc <= 1'b1;
    repeat (50) @(posedge hclk);
  endtask
  // watchdog
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0, r);
    check("ctrl_rst", r, 32'h00000001);
    bus(1'b0, 8'h0C, 32'h0, r);
    check("unmapped", r, 32'h00000000);
    for (int i = 0; i < 23; i++) pair(tbl[i], 5'h01, 5'h01, 1'b1, 1'b1, 4'h0);
    pair(10'h1DD, 5'h01, 5'h01, 1'b0, 1'b0, 4'h3);
    pair(10'h2CA, 5'h01, 5'h02, 1'b1, 1'b1, 4'h0);
    pair(10'h056, 5'h01, 5'h02, 1'b0, 1'b0, 4'h0);
    pair(10'h072, 5'h00, 5'h00, 1'b0, 1'b1, 4'h0);
    t_side();
    pair(10'h088, 5'h01, 5'h02, 1'b1, 1'b1, 4'h0);
    pair(10'h089, 5'h01, 5'h02, 1'b0, 1'b0, 4'h0);
    pair(10'h044, 5'h03, 5'h03, 1'b1, 1'b0, 4'h0);
    pair(10'h171, 5'h00, 5'h00, 1'b0, 1'b1, 4'h0);
    t_hold(CLS_CR);
    t_hold(CLS_RESP);
    t_stall();
    bus(1'b1, STAT_OFS, 32'hFFFFFFFF, r);
    bus(1'b0, STAT_OFS, 32'h0, r);
    check("status", r, 32'h00000000);
    bus(1'b0, CNT_OFS, 32'h0, r);
    check("count", r & 32'h0000FFFF, 32'(rel_n));
    bus(1'b1, CTRL_OFS, 32'h00000003, r);
    bus(1'b0, CTRL_OFS, 32'h0, r);
    check("ctrl", r, 32'h00000003);
    pair(10'h08A, 5'h01, 5'h01, 1'b1, 1'b1, 4'h0);
    stop_test();
  end
endmodule
